// [verilog/adsq_top.sv]
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
//
// Behaviour
// - end of conversion raises the converter interrupt request
// - three clock-select bits in control 0 choose the divider
// - converter runs only while power-down bit is zero
// - channel-enable bits make each shared pin analog or plain I/O
// - direction bits pick the analog pin; data bit 0 grounds it
// - interrupt needs both global and converter enables at one
// - start bit 0 to 1 to 0 starts a conversion
// - busy flag drops low at end; result registers hold value
// - conversion takes sixteen divided converter clock periods
// - result is twelve bits, full scale all ones
// - amplifier enable bit powers the amplifier on or off
// - offset-mode bit with amplifier enabled enters cancellation
// - reference-select bit picks inverting or non-inverting reference
// - software steps four-bit trim until result bit flips
// - amplifier result bit reflects amplifier output state
// - clearing offset-mode bit returns to normal operation
// - two-bit shared pin code: io, noninv, ref, both
// - analog use of shared pin kills its I/O and pull-high
// - single-bit selects route inverting input and output pins
// - three-bit field picks internal reference supply fraction
// - start held high keeps converter in reset, busy high
// - at end device clears busy and sets interrupt request flag
// - divider ratio set by code, 010 gives /3, 101 /6
// - input-select bit picks analog pins or amplifier output
module adsq_top #(
   parameter int NCH = 20
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic [adsq_pkg::RES_W-1:0] conv_sample,
   input wire logic amp_output_async,
   output logic conv_power_on,
   output logic conv_input_source_sel,
   output logic [NCH-1:0] chan_analog,
   output logic [7:0] chan_route,
   output logic [7:0] chan_ground_n,
   output logic conv_irq_req,
   output logic amp_power_on,
   output logic amp_offset_mode,
   output logic offset_ref_input_sel,
   output logic [3:0] offset_trim_field,
   output logic [2:0] amp_internal_ref_sel,
   output logic amp_noninv_input,
   output logic ext_ref_en,
   output logic ref_pin_io_en,
   output logic amp_inv_input,
   output logic amp_output_pin
);
   import adsq_pkg::*;

   logic [7:0] c0_reg, c1_reg, amp_reg, pdir_reg, pdat_reg;
   logic [7:0] ch0_reg, ch1_reg, ch2_reg;
   logic gie_reg, cie_reg, irqf_reg;
   logic [RES_W-1:0] res_reg;
   logic [4:0] tcnt_reg;
   logic busy_reg, ampo_s1_reg, ampo_s2_reg;
   logic [7:0] rdata_next;
   adsq_state_t st_reg;
   logic tick, done;

   function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
      hit = (a == r);
   endfunction

   // ----------------------------------------
   // software writable registers
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         c0_reg <= CTRL0_RST;
         c1_reg <= BYTE_ZERO;
         amp_reg <= BYTE_ZERO;
         pdir_reg <= BYTE_ZERO;
         pdat_reg <= PDAT_RST;
         ch0_reg <= BYTE_ZERO;
         ch1_reg <= BYTE_ZERO;
         ch2_reg <= BYTE_ZERO;
         gie_reg <= 1'b0;
         cie_reg <= 1'b0;
      end else if (ce && wr) begin
         if (hit(addr, ADDR_CTRL0)) c0_reg <= wdata;
         if (hit(addr, ADDR_CTRL1)) c1_reg <= wdata;
         if (hit(addr, ADDR_AMPC)) amp_reg <= wdata;
         if (hit(addr, ADDR_PDIR)) pdir_reg <= wdata;
         if (hit(addr, ADDR_PDAT)) pdat_reg <= wdata;
         if (hit(addr, ADDR_CHEN0)) ch0_reg <= wdata;
         if (hit(addr, ADDR_CHEN1)) ch1_reg <= wdata;
         if (hit(addr, ADDR_CHEN2)) ch2_reg <= wdata;
         if (hit(addr, ADDR_IRQC0)) gie_reg <= wdata[IC0_GIE];
         if (hit(addr, ADDR_IRQC1)) cie_reg <= wdata[IC1_CIE];
      end
   end

   wire start_bit = c0_reg[C0_START];
   wire pdn = c0_reg[C0_PDN];

   adsq_clkdiv u_div (
      .mclk(mclk),
      .rstn(rstn),
      .ce(ce),
      .run(st_reg == ST_CONV),
      .sel(c0_reg[C0_CLKSEL_LO +: 3]),
      .tick(tick)
   );

   // ----------------------------------------
   // conversion sequencer
   // ----------------------------------------
   // armed waits for start to fall; a start held high keeps the
   // converter in reset rather than converting
   assign done = (st_reg == ST_CONV) && tick && (tcnt_reg == 5'(CONV_TAD - 1));

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= ST_IDLE;
         tcnt_reg <= 5'h0;
         busy_reg <= 1'b0;
      end else if (ce) begin
         case (st_reg)
            ST_IDLE: begin
               if (start_bit && !pdn) begin
                  st_reg <= ST_ARMED;
                  busy_reg <= 1'b1;
               end
            end
            ST_ARMED: begin
               if (pdn) begin
                  st_reg <= ST_IDLE;
                  busy_reg <= 1'b0;
               end else if (!start_bit) begin
                  st_reg <= ST_CONV;
                  tcnt_reg <= 5'h0;
               end
            end
            ST_CONV: begin
               if (pdn) begin
                  st_reg <= ST_IDLE;
                  busy_reg <= 1'b0;
               end else if (start_bit) begin
                  st_reg <= ST_ARMED;
               end else if (done) begin
                  st_reg <= ST_IDLE;
                  busy_reg <= 1'b0;
               end else if (tick) begin
                  tcnt_reg <= tcnt_reg + 5'h1;
               end
            end
            default: begin
               st_reg <= ST_IDLE;
               busy_reg <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // result, request flag, amplifier sync
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         res_reg <= '0;
      end else if (ce && done && !pdn && !start_bit) begin
         res_reg <= conv_sample;
      end
   end

   // set wins over a same-cycle software clear
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         irqf_reg <= 1'b0;
      end else if (ce) begin
         if (done && !pdn && !start_bit) begin
            irqf_reg <= 1'b1;
         end else if (wr && hit(addr, ADDR_IRQF) && !wdata[0]) begin
            irqf_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ampo_s1_reg <= 1'b0;
         ampo_s2_reg <= 1'b0;
      end else if (ce) begin
         ampo_s1_reg <= amp_output_async;
         ampo_s2_reg <= ampo_s1_reg;
      end
   end

   // ----------------------------------------
   // read port
   // ----------------------------------------
   always_comb begin
      rdata_next = BYTE_ZERO;
      case (addr)
         ADDR_CTRL0: begin
            rdata_next = c0_reg;
            rdata_next[C0_BUSY] = busy_reg;
         end
         ADDR_CTRL1: rdata_next = c1_reg;
         ADDR_CHEN0: rdata_next = ch0_reg;
         ADDR_CHEN1: rdata_next = ch1_reg;
         ADDR_CHEN2: rdata_next = ch2_reg;
         ADDR_PDIR: rdata_next = pdir_reg;
         ADDR_PDAT: rdata_next = pdat_reg;
         ADDR_IRQC0: rdata_next[IC0_GIE] = gie_reg;
         ADDR_IRQC1: rdata_next[IC1_CIE] = cie_reg;
         ADDR_RESL: rdata_next = res_reg[7:0];
         ADDR_RESH: rdata_next = {4'h0, res_reg[RES_W-1:8]};
         ADDR_AMPC: begin
            rdata_next = amp_reg;
            rdata_next[AC_RESULT] = ampo_s2_reg;
         end
         ADDR_IRQF: rdata_next[0] = irqf_reg;
         default: rdata_next = BYTE_ZERO;
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rdata <= BYTE_ZERO;
      end else if (ce) begin
         rdata <= rd ? rdata_next : BYTE_ZERO;
      end
   end

   // ----------------------------------------
   // registered analog controls
   // ----------------------------------------
   logic [NCH-1:0] chan_all;
   assign chan_all = NCH'({ch2_reg[3:0], ch1_reg, ch0_reg});
   wire [1:0] refpin = c1_reg[C1_REFPIN_LO +: 2];

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         conv_power_on <= 1'b0;
         conv_input_source_sel <= 1'b0;
         chan_analog <= '0;
         chan_route <= BYTE_ZERO;
         chan_ground_n <= BYTE_ZERO;
         conv_irq_req <= 1'b0;
         amp_power_on <= 1'b0;
         amp_offset_mode <= 1'b0;
         offset_ref_input_sel <= 1'b0;
         offset_trim_field <= 4'h0;
         amp_internal_ref_sel <= 3'h0;
         amp_noninv_input <= 1'b0;
         ext_ref_en <= 1'b0;
         ref_pin_io_en <= 1'b1;
         amp_inv_input <= 1'b0;
         amp_output_pin <= 1'b0;
      end else if (ce) begin
         conv_power_on <= !pdn;
         conv_input_source_sel <= c1_reg[C1_INSEL];
         chan_analog <= chan_all;
         chan_route <= pdir_reg;
         chan_ground_n <= pdat_reg;
         conv_irq_req <= irqf_reg && gie_reg && cie_reg;
         amp_power_on <= amp_reg[AC_EN];
         amp_offset_mode <= amp_reg[AC_EN] && amp_reg[AC_OFSM];
         offset_ref_input_sel <= amp_reg[AC_REFSEL];
         offset_trim_field <= amp_reg[AC_TRIM_LO +: 4];
         amp_internal_ref_sel <= c1_reg[C1_IREF_LO +: 3];
         amp_noninv_input <= (refpin == REFPIN_NONINV) || (refpin == REFPIN_BOTH);
         ext_ref_en <= (refpin == REFPIN_EXTREF) || (refpin == REFPIN_BOTH);
         ref_pin_io_en <= (refpin == REFPIN_IO);
         amp_inv_input <= c1_reg[C1_INVSEL];
         amp_output_pin <= c1_reg[C1_OUTSEL];
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   // cycle count of the running conversion, judged against the selected ratio;
   // a clock code changed mid-run would trip it, so the code is set before start
   logic [7:0] conv_cyc_reg;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         conv_cyc_reg <= 8'h00;
      end else if (ce) begin
         if (st_reg == ST_CONV) begin
            conv_cyc_reg <= conv_cyc_reg + 8'h01;
         end else begin
            conv_cyc_reg <= 8'h00;
         end
      end
   end

   sequence s_conv_end;
      $rose(st_reg == ST_CONV) ##1 (st_reg == ST_CONV) [*2];
   endsequence

   a_busy_during_conv: assert property (@(posedge mclk) disable iff (!rstn)
      (st_reg == ST_CONV) |-> busy_reg)
      else $error("busy low during conversion");
   a_busy_clear_end: assert property (@(posedge mclk) disable iff (!rstn)
      (ce && done && !pdn && !start_bit) |=> !busy_reg)
      else $error("busy not cleared at end");
   a_flag_set_end: assert property (@(posedge mclk) disable iff (!rstn)
      (ce && done && !pdn && !start_bit) |=> irqf_reg)
      else $error("request flag not set");
   a_result_load: assert property (@(posedge mclk) disable iff (!rstn)
      (ce && done && !pdn && !start_bit) |=> res_reg == $past(conv_sample))
      else $error("result not loaded");
   a_held_start_busy: assert property (@(posedge mclk) disable iff (!rstn)
      (ce && start_bit && !pdn && st_reg != ST_ARMED) |=> busy_reg && st_reg == ST_ARMED)
      else $error("held start did not reset converter");
   a_pdn_holds_res: assert property (@(posedge mclk) disable iff (!rstn)
      pdn |=> $stable(res_reg))
      else $error("result changed while powered down");
   a_irq_gate: assert property (@(posedge mclk) disable iff (!rstn)
      (ce && !(gie_reg && cie_reg)) |=> !conv_irq_req)
      else $error("interrupt without both enables");
   a_conv_minimum: assert property (@(posedge mclk) disable iff (!rstn)
      s_conv_end |-> !$fell(busy_reg))
      else $error("conversion ended too early");
   a_offset_gate: assert property (@(posedge mclk) disable iff (!rstn)
      (ce && !amp_reg[AC_EN]) |=> !amp_offset_mode)
      else $error("offset mode without enable");
   a_conv_length: assert property (@(posedge mclk) disable iff (!rstn)
      (ce && done && !pdn && !start_bit) |-> conv_cyc_reg == 8'(CONV_TAD * (int'(c0_reg[C0_CLKSEL_LO +: 3]) + 1)))
      else $error("conversion length differs from sixteen periods");
   a_irq_follow: assert property (@(posedge mclk) disable iff (!rstn)
      (ce && irqf_reg && gie_reg && cie_reg) |=> conv_irq_req)
      else $error("interrupt request missing");
   a_power_follow: assert property (@(posedge mclk) disable iff (!rstn)
      ce |=> (conv_power_on == !$past(pdn)))
      else $error("converter power does not follow power-down bit");
endmodule

// [verilog/adsq_pkg.sv]
package adsq_pkg;
   // ----------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [3:0] ADDR_CTRL0 = 4'h0;
   localparam logic [3:0] ADDR_CTRL1 = 4'h1;
   localparam logic [3:0] ADDR_CHEN0 = 4'h2;
   localparam logic [3:0] ADDR_CHEN1 = 4'h3;
   localparam logic [3:0] ADDR_CHEN2 = 4'h4;
   localparam logic [3:0] ADDR_PDIR = 4'h5;
   localparam logic [3:0] ADDR_PDAT = 4'h6;
   localparam logic [3:0] ADDR_IRQC0 = 4'h7;
   localparam logic [3:0] ADDR_IRQC1 = 4'h8;
   localparam logic [3:0] ADDR_RESL = 4'h9;
   localparam logic [3:0] ADDR_RESH = 4'ha;
   localparam logic [3:0] ADDR_AMPC = 4'hb;
   localparam logic [3:0] ADDR_IRQF = 4'hc;
   // ----------------------------------------
   // control register 0 fields
   // ----------------------------------------
   localparam int C0_CLKSEL_LO = 0;
   localparam int C0_BUSY = 4;
   localparam int C0_START = 5;
   localparam int C0_PDN = 6;
   // ----------------------------------------
   // control register 1 fields
   // ----------------------------------------
   localparam int C1_IREF_LO = 0;
   localparam int C1_INSEL = 3;
   localparam int C1_REFPIN_LO = 4;
   localparam int C1_INVSEL = 6;
   localparam int C1_OUTSEL = 7;
   // ----------------------------------------
   // amplifier control fields
   // ----------------------------------------
   localparam int AC_TRIM_LO = 0;
   localparam int AC_REFSEL = 4;
   localparam int AC_OFSM = 5;
   localparam int AC_RESULT = 6;
   localparam int AC_EN = 7;
   // ----------------------------------------
   // interrupt control fields
   // ----------------------------------------
   localparam int IC0_GIE = 0;
   localparam int IC1_CIE = 0;
   // ----------------------------------------
   // reset values and constants
   // ----------------------------------------
   localparam logic [7:0] CTRL0_RST = 8'h40;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] PDAT_RST = 8'hff;
   localparam int RES_W = 12;
   localparam int CONV_TAD = 16;
   localparam logic [1:0] REFPIN_IO = 2'h0;
   localparam logic [1:0] REFPIN_NONINV = 2'h1;
   localparam logic [1:0] REFPIN_EXTREF = 2'h2;
   localparam logic [1:0] REFPIN_BOTH = 2'h3;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ARMED = 2'b01,
      ST_CONV = 2'b11
   } adsq_state_t;
endpackage

// [verilog/adsq_clkdiv.sv]
`timescale 1ns/10ps
module adsq_clkdiv (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic run,
   input wire logic [2:0] sel,
   output logic tick
);
   import adsq_pkg::*;
   logic [2:0] cnt_reg;

   // ----------------------------------------
   // ratio is code + 1, code 010 -> /3
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cnt_reg <= 3'h0;
         tick <= 1'b0;
      end else if (ce) begin
         if (!run || cnt_reg >= sel) begin
            cnt_reg <= 3'h0;
            tick <= run;
         end else begin
            cnt_reg <= cnt_reg + 3'h1;
            tick <= 1'b0;
         end
      end
   end
endmodule

// [test/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
   import adsq_pkg::*;
   logic mclk, rstn, ce, wr, rd, amp_output_async;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, rv;
   logic [11:0] conv_sample;
   logic conv_power_on, conv_input_source_sel, conv_irq_req, amp_power_on, amp_offset_mode;
   logic offset_ref_input_sel, amp_noninv_input, ext_ref_en, ref_pin_io_en;
   logic amp_inv_input, amp_output_pin;
   logic [19:0] chan_analog;
   logic [7:0] chan_route, chan_ground_n;
   logic [3:0] offset_trim_field;
   logic [2:0] amp_internal_ref_sel;
   int fails, check_count;

   adsq_top #(.NCH(20)) dut_u (.mclk(mclk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .conv_sample(conv_sample),
      .amp_output_async(amp_output_async), .conv_power_on(conv_power_on),
      .conv_input_source_sel(conv_input_source_sel), .chan_analog(chan_analog),
      .chan_route(chan_route), .chan_ground_n(chan_ground_n), .conv_irq_req(conv_irq_req),
      .amp_power_on(amp_power_on), .amp_offset_mode(amp_offset_mode),
      .offset_ref_input_sel(offset_ref_input_sel), .offset_trim_field(offset_trim_field),
      .amp_internal_ref_sel(amp_internal_ref_sel), .amp_noninv_input(amp_noninv_input),
      .ext_ref_en(ext_ref_en), .ref_pin_io_en(ref_pin_io_en), .amp_inv_input(amp_inv_input),
      .amp_output_pin(amp_output_pin));

   // ----------------------------------------
   // clock, bus tasks and compare
   // ----------------------------------------
   initial mclk = 1'b0;
   always #50 mclk = ~mclk;

   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe, so sample just past that edge
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset;
      rd_reg(ADDR_CTRL0, rv);
      chk(rv, CTRL0_RST);
      rd_reg(ADDR_PDAT, rv);
      chk(rv, PDAT_RST);
      chk(conv_power_on, 1'b0);
      chk(ref_pin_io_en, 1'b1);
      rd_reg(4'hd, rv);
      chk(rv, 8'h00);
   endtask

   // start pulse then busy checked just before and just after the nominal end
   task automatic t_conv(input logic [2:0] sel, input logic [11:0] smp);
      int n;
      n = 16 * (sel + 1);
      conv_sample <= smp;
      wr_reg(ADDR_CTRL0, {3'h1, 2'h0, sel});
      wr_reg(ADDR_CTRL0, {3'h0, 2'h0, sel});
      wait_cyc(n);
      rd_reg(ADDR_CTRL0, rv);
      chk(rv[C0_BUSY], 1'b1);
      chk(conv_power_on, 1'b1);
      rd_reg(ADDR_CTRL0, rv);
      chk(rv[C0_BUSY], 1'b0);
      rd_reg(ADDR_RESL, rv);
      chk(rv, smp[7:0]);
      rd_reg(ADDR_RESH, rv);
      chk(rv, {4'h0, smp[11:8]});
   endtask

   task automatic t_irq;
      wr_reg(ADDR_IRQC0, 8'h01);
      t_conv(3'h0, 12'h123);
      rd_reg(ADDR_IRQF, rv);
      chk(rv[0], 1'b1);
      chk(conv_irq_req, 1'b0);
      wr_reg(ADDR_IRQC1, 8'h01);
      wait_cyc(3);
      chk(conv_irq_req, 1'b1);
      wr_reg(ADDR_IRQF, 8'h00);
      wait_cyc(3);
      chk(conv_irq_req, 1'b0);
   endtask

   // start left high keeps the converter reset; the later fall then starts a run
   task automatic t_hold;
      conv_sample <= 12'h0aa;
      wr_reg(ADDR_CTRL0, 8'h20);
      wait_cyc(60);
      rd_reg(ADDR_CTRL0, rv);
      chk(rv[C0_BUSY], 1'b1);
      rd_reg(ADDR_RESL, rv);
      chk(rv, 8'h23);
      wr_reg(ADDR_CTRL0, 8'h00);
      wait_cyc(24);
      rd_reg(ADDR_RESL, rv);
      chk(rv, 8'haa);
   endtask

   task automatic t_pdn;
      wr_reg(ADDR_CTRL0, 8'h40);
      wait_cyc(3);
      chk(conv_power_on, 1'b0);
      conv_sample <= 12'h777;
      wr_reg(ADDR_CTRL0, 8'h60);
      wr_reg(ADDR_CTRL0, 8'h40);
      wait_cyc(40);
      rd_reg(ADDR_CTRL0, rv);
      chk(rv[C0_BUSY], 1'b0);
      rd_reg(ADDR_RESL, rv);
      chk(rv, 8'haa);
   endtask

   task automatic t_amp;
      amp_output_async <= 1'b1;
      wr_reg(ADDR_AMPC, 8'ha5);
      wait_cyc(4);
      chk({amp_power_on, amp_offset_mode, offset_ref_input_sel}, 3'b110);
      rd_reg(ADDR_AMPC, rv);
      chk(rv[AC_RESULT], 1'b1);
      for (int t = 0; t < 16; t++) begin
         wr_reg(ADDR_AMPC, 8'hb0 | t[7:0]);
         wait_cyc(3);
         chk({offset_ref_input_sel, offset_trim_field}, {1'b1, t[3:0]});
      end
      amp_output_async <= 1'b0;
      wait_cyc(4);
      rd_reg(ADDR_AMPC, rv);
      chk(rv[AC_RESULT], 1'b0);
      wr_reg(ADDR_AMPC, 8'h85);
      wait_cyc(3);
      chk(amp_offset_mode, 1'b0);
      wr_reg(ADDR_AMPC, 8'h25);
      wait_cyc(3);
      chk({amp_power_on, amp_offset_mode}, 2'b00);
   endtask

   // every shared pin code with the other ctrl1 fields walked alongside
   task automatic t_pins;
      logic [7:0] v;
      for (int c = 0; c < 4; c++) begin
         v = {c[0], c[1], c[1:0], c[0], c[2:0] + 3'h5};
         wr_reg(ADDR_CTRL1, v);
         wait_cyc(3);
         chk({amp_noninv_input, ext_ref_en}, {c[0], c[1]});
         chk(ref_pin_io_en, c[1:0] == 2'b00);
         chk({amp_inv_input, amp_output_pin}, {v[6], v[7]});
         chk({conv_input_source_sel, amp_internal_ref_sel}, v[3:0]);
      end
   endtask

   task automatic t_chan;
      wr_reg(ADDR_CHEN0, 8'h5a);
      wr_reg(ADDR_CHEN1, 8'hc3);
      wr_reg(ADDR_CHEN2, 8'h09);
      wr_reg(ADDR_PDIR, 8'h81);
      wr_reg(ADDR_PDAT, 8'h7e);
      wait_cyc(3);
      chk(chan_analog, 20'h9c35a);
      chk(chan_route, 8'h81);
      chk(chan_ground_n, 8'h7e);
   endtask

   // ----------------------------------------
   // run control
   // ----------------------------------------
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // whole sequence needs well under 2000 cycles
   initial begin
      #2_000_000;
      fails++;
      test_done();
   end

   initial begin
      rstn = 1'b0;
      ce = 1'b1;
      addr = 4'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      conv_sample = 12'h000;
      amp_output_async = 1'b0;
      fails = 0;
      check_count = 0;
      wait_cyc(16);
      rstn <= 1'b1;
      t_reset();
      t_chan();
      t_conv(3'h2, 12'hfff);
      t_conv(3'h5, 12'h5a3);
      t_conv(3'h0, 12'h001);
      t_irq();
      t_hold();
      t_pdn();
      t_amp();
      t_pins();
      test_done();
   end
endmodule
